// File: design/flash_prot_host.sv
// Host controller driving a byte-wide NOR flash through its pins
//
// Overview of operation
// - High-voltage ID: A9 high, A6/A1 low
// - Protect readout: group on top, A1 high
// - Reset pin high voltage unprotects temporarily
// - Write: CE and WE low, OE high
// - Unlock cycles precede program and erase
`timescale 1ns/100ps
`include "flash_prot_consts.svh"
module flash_prot_host #(
    parameter int ADDR_W = `ADDR_W
) (
    // Clock and reset
    input  wire logic                   mclk,
    input  wire logic                   rst,
    // Request port
    input  wire logic                   req,
    input  wire flash_prot_pkg::op_e    req_op,
    input  wire logic [ADDR_W-1:0]      req_addr,
    input  wire logic [7:0]             req_data,
    output logic                        busy,
    output logic                        done,
    output logic [7:0]                  rdata,
    output logic [4:0]                  sector_index,
    output logic [2:0]                  protect_group_index,
    // Device status
    input  wire logic                   lockout_threshold,
    // Flash pins
    output logic [ADDR_W-1:0]           fa,
    output logic [7:0]                  dq_out,
    output logic                        dq_oe,
    input  wire logic [7:0]             dq_in,
    output logic                        ce_n,
    output logic                        oe_n,
    output logic                        we_n,
    output logic                        reset_n,
    output logic                        reset_hv,
    output logic                        id_high_voltage
);
    import flash_prot_pkg::*;

    // Refuse any other address width at elaboration
    if (ADDR_W != `ADDR_W) begin : g_bad_width
        $error("ADDR_W must be 21");
    end

    state_e          state;
    op_e             op;
    logic [ADDR_W-1:0] addr;
    logic [7:0]      data;
    logic [2:0]      step;
    logic [2:0]      nsteps;
    logic [3:0]      cnt;
    logic [7:0]      dq_s1;
    logic [7:0]      dq_s2;
    logic            lko_s1;
    logic            lko_s2;

    // Input synchronisers
    always_ff @(posedge mclk or posedge rst) begin
        if (rst) begin
            dq_s1  <= 8'h00;
            dq_s2  <= 8'h00;
            lko_s1 <= 1'b1;
            lko_s2 <= 1'b1;
        end else begin
            dq_s1  <= dq_in;
            dq_s2  <= dq_s1;
            lko_s1 <= lockout_threshold;
            lko_s2 <= lko_s1;
        end
    end

    // Number of write cycles per operation
    function automatic logic [2:0] write_count(input op_e o);
        case (o)
            OP_PROGRAM:  write_count = 3'h4;
            OP_ERASE:    write_count = 3'h6;
            OP_ID_CMD:   write_count = 3'h3;
            OP_PROT_CMD: write_count = 3'h3;
            OP_READ:     write_count = 3'h1;  // Leaves autoselect first
            default:     write_count = 3'h0;
        endcase
    endfunction

    // Address and data of each write cycle
    function automatic logic [ADDR_W+7:0] write_word(input op_e o, input logic [2:0] s,
                                                     input logic [ADDR_W-1:0] a,
                                                     input logic [7:0] d);
        logic [7:0] c;
        c = `CMD_AUTOSEL;
        if (o == OP_READ) begin
            write_word = {`CMD_ADDR_A, `CMD_RESET};
        end else begin
            case (s)
                3'h0:    write_word = {`CMD_ADDR_A, `CMD_DATA_A};
                3'h1:    write_word = {`CMD_ADDR_B, `CMD_DATA_B};
                3'h2: begin
                    if (o == OP_PROGRAM) c = `CMD_PROGRAM;
                    else if (o == OP_ERASE) c = `CMD_ERASE;
                    write_word = {`CMD_ADDR_A, c};
                end
                3'h3: begin
                    if (o == OP_PROGRAM) write_word = {a, d};
                    else write_word = {`CMD_ADDR_A, `CMD_DATA_A};
                end
                3'h4:    write_word = {`CMD_ADDR_B, `CMD_DATA_B};
                default: write_word = {a, `CMD_SECT_ERASE};
            endcase
        end
    endfunction

    // Read address for identification and protect readout
    function automatic logic [ADDR_W-1:0] id_addr(input op_e o, input logic [ADDR_W-1:0] a);
        logic [ADDR_W-1:0] r;
        r = '0;
        r[`ID_A0] = a[`ID_A0];
        if (o == OP_PROT_HV || o == OP_PROT_CMD) begin
            r[`GROUP_MSB:`GROUP_LSB] = a[`GROUP_MSB:`GROUP_LSB];
            r[`ID_A1] = 1'b1;
            r[`ID_A0] = 1'b0;
        end
        r[`ID_A6] = 1'b0;
        id_addr = r;
    endfunction

    // Sequencer
    always_ff @(posedge mclk or posedge rst) begin
        if (rst) begin
            state <= ST_IDLE;
            op    <= OP_READ;
            addr  <= '0;
            data  <= 8'h00;
            step  <= 3'h0;
            nsteps <= 3'h0;
            cnt   <= 4'h0;
        end else begin
            case (state)
                ST_IDLE: begin
                    if (req) begin
                        op     <= req_op;
                        addr   <= req_addr;
                        data   <= req_data;
                        step   <= 3'h0;
                        nsteps <= write_count(req_op);
                        cnt    <= `SETUP_CYCLES;
                        if (req_op == OP_HW_RESET) state <= ST_RESET;
                        else if (req_op == OP_TEMP_ON || req_op == OP_TEMP_OFF)
                            state <= ST_DONE;
                        else if (write_count(req_op) != 3'h0 && lko_s2)
                            state <= ST_DONE;
                        else state <= ST_SETUP;
                    end
                end
                ST_SETUP: begin
                    if (cnt != 4'h0) cnt <= cnt - 4'h1;
                    else begin
                        cnt   <= `PHASE_CYCLES;
                        state <= (step < nsteps) ? ST_WRITE : ST_READ;
                    end
                end
                ST_WRITE: begin
                    if (cnt != 4'h0) cnt <= cnt - 4'h1;
                    else begin
                        cnt   <= `SETUP_CYCLES;
                        state <= ST_HOLD;
                    end
                end
                ST_HOLD: begin
                    if (cnt != 4'h0) cnt <= cnt - 4'h1;
                    else begin
                        step <= step + 3'h1;
                        cnt  <= `SETUP_CYCLES;
                        // Read ops still need their read phase after the writes
                        if (step + 3'h1 < nsteps || op == OP_READ || op == OP_ID_CMD
                                || op == OP_PROT_CMD)
                            state <= ST_SETUP;
                        else state <= ST_DONE;
                    end
                end
                ST_READ: begin
                    if (cnt != 4'h0) cnt <= cnt - 4'h1;
                    else state <= ST_DONE;
                end
                ST_RESET: begin
                    if (cnt != 4'h0) cnt <= cnt - 4'h1;
                    else begin
                        cnt   <= `PHASE_CYCLES;
                        state <= (cnt == 4'h0 && reset_n == 1'b0) ? ST_DONE : ST_RESET;
                    end
                end
                ST_DONE:  state <= ST_IDLE;
                default:  state <= ST_IDLE;
            endcase
        end
    end

    // Pin drive
    always_ff @(posedge mclk or posedge rst) begin
        if (rst) begin
            fa      <= '0;
            dq_out  <= 8'h00;
            dq_oe   <= 1'b0;
            ce_n    <= 1'b1;
            oe_n    <= 1'b1;
            we_n    <= 1'b1;
            reset_n <= 1'b1;
            id_high_voltage <= 1'b0;
        end else begin
            ce_n    <= 1'b1;
            we_n    <= 1'b1;
            oe_n    <= 1'b1;
            dq_oe   <= 1'b0;
            reset_n <= state != ST_RESET;
            id_high_voltage <= 1'b0;
            if (state == ST_SETUP || state == ST_WRITE || state == ST_HOLD) begin
                if (step < nsteps) begin
                    {fa, dq_out} <= write_word(op, step, addr, data);
                    ce_n  <= 1'b0;
                    oe_n  <= 1'b1;
                    we_n  <= state != ST_WRITE;
                    dq_oe <= 1'b1;
                end else begin
                    fa   <= (op == OP_READ || op == OP_PROGRAM || op == OP_ERASE)
                            ? addr : id_addr(op, addr);
                    ce_n <= 1'b0;
                end
            end
            if (state == ST_READ) begin
                ce_n <= 1'b0;
                oe_n <= 1'b0;
                fa   <= (op == OP_READ) ? addr : id_addr(op, addr);
                id_high_voltage <= op == OP_ID_HV || op == OP_PROT_HV;
            end
        end
    end

    // Temporary unprotect level
    always_ff @(posedge mclk or posedge rst) begin
        if (rst) reset_hv <= 1'b0;
        else if (state == ST_IDLE && req && req_op == OP_TEMP_ON) reset_hv <= 1'b1;
        else if (state == ST_IDLE && req && req_op == OP_TEMP_OFF) reset_hv <= 1'b0;
    end

    // Answer to the requester
    always_ff @(posedge mclk or posedge rst) begin
        if (rst) begin
            busy  <= 1'b0;
            done  <= 1'b0;
            rdata <= 8'h00;
            sector_index        <= 5'h00;
            protect_group_index <= 3'h0;
        end else begin
            busy <= state != ST_IDLE && state != ST_DONE || (state == ST_IDLE && req);
            done <= state == ST_DONE;
            if (state == ST_READ && cnt == 4'h0) begin
                if (op == OP_PROT_HV || op == OP_PROT_CMD)
                    rdata <= {7'h00, dq_s2[`PROT_BIT]};
                else rdata <= dq_s2;
            end
            if (state == ST_IDLE && req) begin
                sector_index        <= req_addr[`SECTOR_MSB:`SECTOR_LSB];
                protect_group_index <= req_addr[`GROUP_MSB:`GROUP_LSB];
            end
        end
    end
endmodule : flash_prot_host

// File: design/flash_prot_consts.svh
// Constants for the flash protection host controller
`ifndef FLASH_PROT_CONSTS_SVH
`define FLASH_PROT_CONSTS_SVH
`define ADDR_W          21
`define SECTOR_LSB      16
`define SECTOR_MSB      20
`define GROUP_LSB       18
`define GROUP_MSB       20
`define ID_A0           0
`define ID_A1           1
`define ID_A6           6
`define CMD_ADDR_A      21'h000555
`define CMD_ADDR_B      21'h0002AA
`define CMD_DATA_A      8'hAA
`define CMD_DATA_B      8'h55
`define CMD_AUTOSEL     8'h90
`define CMD_PROGRAM     8'hA0
`define CMD_ERASE       8'h80
`define CMD_SECT_ERASE  8'h30
`define CMD_RESET       8'hF0
`define PROT_BIT        0
`define PHASE_CYCLES    4'h3
`define SETUP_CYCLES    4'h1
`endif

// File: design/flash_prot_pkg.sv
// Types for the flash protection host controller
package flash_prot_pkg;
    typedef enum logic [3:0] {
        OP_READ     = 4'h0,
        OP_PROGRAM  = 4'h1,
        OP_ERASE    = 4'h2,
        OP_ID_HV    = 4'h3,
        OP_ID_CMD   = 4'h4,
        OP_PROT_HV  = 4'h5,
        OP_PROT_CMD = 4'h6,
        OP_TEMP_ON  = 4'h7,
        OP_TEMP_OFF = 4'h8,
        OP_HW_RESET = 4'h9
    } op_e;
    typedef enum logic [6:0] {
        ST_IDLE   = 7'h01,
        ST_SETUP  = 7'h02,
        ST_WRITE  = 7'h04,
        ST_HOLD   = 7'h08,
        ST_READ   = 7'h10,
        ST_RESET  = 7'h20,
        ST_DONE   = 7'h40
    } state_e;
endpackage : flash_prot_pkg

// File: test/flash_prot_host_chk.sv
// Pin-level and request-side checks for the flash protection host
`timescale 1ns/100ps
module flash_prot_host_chk #(
    parameter int ADDR_W = 21
) (
    // Clock and reset
    input wire logic              mclk,
    input wire logic              rst,
    // Request side
    input wire logic              busy,
    input wire logic [ADDR_W-1:0] req_addr,
    input wire logic [4:0]        sector_index,
    input wire logic [2:0]        protect_group_index,
    input wire logic              lockout_threshold,
    // Flash pins
    input wire logic [ADDR_W-1:0] fa,
    input wire logic              dq_oe,
    input wire logic              ce_n,
    input wire logic              oe_n,
    input wire logic              we_n,
    input wire logic              reset_n,
    input wire logic              reset_hv,
    input wire logic              id_high_voltage
);
    logic [ADDR_W-1:0] addr_d;
    always_ff @(posedge mclk) begin
        addr_d <= req_addr;
    end
    default clocking @(posedge mclk);
    endclocking
    default disable iff (rst);
    a_write_strobe_qual: assert property (!we_n |-> !ce_n && oe_n)
        else $error("write strobe without select");
    a_drive_oe_high: assert property (dq_oe |-> oe_n)
        else $error("data driven during read");
    a_read_no_write: assert property (!oe_n |-> we_n && !dq_oe)
        else $error("write during read");
    a_id_a6_low: assert property (id_high_voltage && !oe_n |-> !fa[6])
        else $error("id read with A6 high");
    a_prot_a0_low: assert property (id_high_voltage && !oe_n && fa[1] |-> !fa[0])
        else $error("protect readout with A0 high");
    a_sector_latch: assert property ($rose(busy) |-> sector_index == addr_d[20:16])
        else $error("sector index wrong");
    a_group_latch: assert property ($rose(busy) |-> protect_group_index == addr_d[20:18])
        else $error("group index wrong");
    a_hv_reset_level: assert property (reset_hv |-> reset_n)
        else $error("reset low with high voltage");
    a_reset_no_write: assert property (!reset_n |-> we_n)
        else $error("write during reset pulse");
    a_lockout_quiet: assert property (lockout_threshold [*4] |-> we_n)
        else $error("write below lockout");
endmodule : flash_prot_host_chk

bind flash_prot_host flash_prot_host_chk #(.ADDR_W(ADDR_W)) u_chk (
    .mclk(mclk), .rst(rst), .busy(busy), .req_addr(req_addr), .sector_index(sector_index),
    .protect_group_index(protect_group_index), .lockout_threshold(lockout_threshold),
    .fa(fa), .dq_oe(dq_oe), .ce_n(ce_n), .oe_n(oe_n), .we_n(we_n), .reset_n(reset_n),
    .reset_hv(reset_hv), .id_high_voltage(id_high_voltage));

// File: test/flash_dev_model.sv
// Behavioural model of the flash device behind the host
`timescale 1ns/100ps
`include "flash_prot_consts.svh"
module flash_dev_model #(
    parameter logic [7:0] MAKER_ID = 8'h3C, // Arbitrary value
    parameter logic [7:0] PART_ID  = 8'hC3  // Arbitrary value
) (
    // Flash pins
    input  wire logic [20:0] fa,
    input  wire logic [7:0]  dq_out,
    input  wire logic        dq_oe,
    output logic      [7:0]  dq_in,
    input  wire logic        ce_n,
    input  wire logic        oe_n,
    input  wire logic        we_n,
    input  wire logic        reset_n,
    input  wire logic        reset_hv,
    input  wire logic        id_high_voltage,
    // Supply state
    input  wire logic        lockout
);
    logic [7:0] mem [int];
    logic [7:0] prot  = 8'h00;
    logic [2:0] step  = 3'h0;
    logic       auto  = 1'b0;
    logic       armed = 1'b0;
    logic       we_seen_high = 1'b0;
    logic [7:0] rd    = 8'hFF;
    logic [7:0] lastv = 8'h00;
    logic [7:0] wd;
    logic       locked;
    always @(fa or oe_n or ce_n or id_high_voltage or auto or reset_n or prot) begin
        if (id_high_voltage || auto) begin
            rd = fa[1] ? {7'h00, prot[fa[20:18]]} : (fa[0] ? PART_ID : MAKER_ID);
        end else if (!oe_n) begin
            rd = mem.exists(int'(fa)) ? mem[int'(fa)] : 8'hFF;
        end
        if (!ce_n && !oe_n && reset_n) begin
            lastv = rd;
        end
    end
    assign dq_in = (!ce_n && !oe_n && reset_n) ? rd : ~lastv;
    always @(negedge reset_n or posedge lockout) begin
        step = 3'h0;
        auto = 1'b0;
    end
    // Strobe held low since power-up arms nothing
    always @(we_n) begin
        if (we_n === 1'b0 && we_seen_high) armed = 1'b1;
        if (we_n === 1'b1) we_seen_high = 1'b1;
    end
    always @(posedge we_n) begin
        wd = dq_oe ? dq_out : ~dq_out;
        locked = prot[fa[20:18]] && !reset_hv;
        if (armed && !ce_n && oe_n && reset_n && !lockout) begin
            if (wd == `CMD_RESET) begin
                step = 3'h0;
                auto = 1'b0;
            end else case (step)
                3'h0, 3'h3: step = (wd == `CMD_DATA_A) ? step + 3'h1 : 3'h0;
                3'h1, 3'h4: step = (wd == `CMD_DATA_B) ? step + 3'h1 + {2'h0, step[2]} : 3'h0;
                3'h2: begin
                    auto = (wd == `CMD_AUTOSEL);
                    step = (wd == `CMD_PROGRAM) ? 3'h5 : (wd == `CMD_ERASE) ? 3'h3 : 3'h0;
                end
                3'h5: begin
                    if (!locked) mem[int'(fa)] = wd;
                    step = 3'h0;
                end
                default: begin
                    if (wd == `CMD_SECT_ERASE && !locked) begin
                        foreach (mem[k]) if (k[20:16] == fa[20:16]) mem[k] = 8'hFF;
                    end
                    step = 3'h0;
                end
            endcase
        end
    end
endmodule : flash_dev_model

// File: test/flash_prot_host_tb_top.sv
// Self-checking bench for the flash protection host
`timescale 1ns/100ps
module flash_prot_host_tb_top;
    import flash_prot_pkg::*;
    localparam logic [7:0] MAKER_ID = 8'h3C; // Arbitrary value
    localparam logic [7:0] PART_ID  = 8'hC3; // Arbitrary value
    logic        mclk = 1'b0, rst = 1'b1, req = 1'b0, lockout_threshold = 1'b0;
    op_e         req_op = OP_READ;
    logic [20:0] req_addr = 21'h000000, fa, a1, a2;
    logic [7:0]  req_data = 8'h00, rdata, dq_out, dq_in, d1;
    logic        busy, done, dq_oe, ce_n, oe_n, we_n, reset_n, reset_hv, id_high_voltage;
    logic [15:0] lfsr_state = 16'h0054;
    logic [8:0]  exp_q [$];
    logic [8:0]  note;
    int          bad_count = 0, checks_done = 0;
    always #25 mclk = ~mclk;
    flash_prot_host DUT (.mclk(mclk), .rst(rst), .req(req), .req_op(req_op),
        .req_addr(req_addr), .req_data(req_data), .busy(busy), .done(done), .rdata(rdata),
        .sector_index(), .protect_group_index(), .lockout_threshold(lockout_threshold),
        .fa(fa), .dq_out(dq_out), .dq_oe(dq_oe), .dq_in(dq_in), .ce_n(ce_n), .oe_n(oe_n),
        .we_n(we_n), .reset_n(reset_n), .reset_hv(reset_hv), .id_high_voltage(id_high_voltage));
    flash_dev_model #(.MAKER_ID(MAKER_ID), .PART_ID(PART_ID)) dev (.fa(fa), .dq_out(dq_out),
        .dq_oe(dq_oe), .dq_in(dq_in), .ce_n(ce_n), .oe_n(oe_n), .we_n(we_n),
        .reset_n(reset_n), .reset_hv(reset_hv), .id_high_voltage(id_high_voltage),
        .lockout(lockout_threshold));
    function automatic logic [15:0] lfsr_next(input logic [15:0] s);
        return {s[14:0], s[15] ^ s[13] ^ s[12] ^ s[10]};
    endfunction : lfsr_next
    task automatic complete_run();
        if (bad_count == 0 && checks_done > 0) $display("TEST PASSED");
        else $display("TEST FAILED");
        $finish;
    endtask : complete_run
    task automatic check(input logic [7:0] seen, input logic [7:0] exp);
        checks_done++;
        if (seen !== exp) begin
            bad_count++;
            $display("Error at %0t: seen %h expected %h", $time, seen, exp);
        end
    endtask : check
    task automatic run_op(input op_e op, input logic [20:0] a, input logic [7:0] d,
                          input logic [8:0] n_exp);
        int n;
        exp_q.push_back(n_exp);
        req_op <= op;
        req_addr <= a;
        req_data <= d;
        req <= 1'b1;
        @(posedge mclk);
        req <= 1'b0;
        for (n = 0; n < 300 && done !== 1'b1; n++) @(posedge mclk);
        if (n == 300) begin
            bad_count++;
            complete_run();
        end
    endtask : run_op
    task automatic rd_op(input op_e op, input logic [20:0] a, input logic [7:0] e);
        run_op(op, a, 8'h00, {1'b1, e});
    endtask : rd_op
    always @(posedge mclk) begin
        if (done === 1'b1 && exp_q.size() > 0) begin
            note = exp_q.pop_front();
            if (note[8])
                check(rdata, note[7:0]);
        end
    end
    initial begin
        repeat (4) @(posedge mclk);
        rst <= 1'b0;
        repeat (3) @(posedge mclk);
        for (int g = 0; g < 8; g++)
            rd_op(OP_PROT_HV, {g[2:0], 18'h00000}, 8'h00);
        rd_op(OP_ID_HV, 21'h000000, MAKER_ID);
        rd_op(OP_ID_HV, 21'h000001, PART_ID);
        rd_op(OP_ID_CMD, 21'h000000, MAKER_ID);
        rd_op(OP_ID_CMD, 21'h000001, PART_ID);
        lfsr_state = lfsr_next(lfsr_next(lfsr_state));
        a1 = {3'h2, lfsr_state, 2'h1};
        a2 = {3'h5, lfsr_state, 2'h2};
        d1 = lfsr_state[7:0] & 8'hFE;
        rd_op(OP_READ, a1, 8'hFF);
        run_op(OP_PROGRAM, a1, d1, 9'h000);
        rd_op(OP_READ, a1, d1);
        dev.prot[5] = 1'b1;
        rd_op(OP_PROT_HV, a2, 8'h01);
        rd_op(OP_PROT_CMD, a2, 8'h01);
        run_op(OP_PROGRAM, a2, d1, 9'h000);
        rd_op(OP_READ, a2, 8'hFF);
        run_op(OP_TEMP_ON, a2, 8'h00, 9'h000);
        run_op(OP_PROGRAM, a2, d1, 9'h000);
        run_op(OP_TEMP_OFF, a2, 8'h00, 9'h000);
        rd_op(OP_READ, a2, d1);
        run_op(OP_PROGRAM, a2 ^ 21'h000100, d1, 9'h000);
        rd_op(OP_READ, a2 ^ 21'h000100, 8'hFF);
        dev.prot[5] = 1'b0;
        run_op(OP_ERASE, a2, 8'h00, 9'h000);
        rd_op(OP_READ, a2, 8'hFF);
        lockout_threshold <= 1'b1;
        repeat (4) @(posedge mclk);
        run_op(OP_PROGRAM, a1 ^ 21'h000010, d1, 9'h000);
        lockout_threshold <= 1'b0;
        repeat (4) @(posedge mclk);
        rd_op(OP_READ, a1 ^ 21'h000010, 8'hFF);
        run_op(OP_ID_CMD, 21'h000000, 8'h00, 9'h000);
        run_op(OP_HW_RESET, 21'h000000, 8'h00, 9'h000);
        check({7'h00, dev.auto}, 8'h00);
        complete_run();
    end
endmodule : flash_prot_host_tb_top
